/* sim/pmcu_host.sv */
// Host model driving register writes and reads of the power mode command unit.
`timescale 1ns/1ps
module pmcu_host (
    input wire logic clk,
    output logic ce,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic set_ce(input logic v);
        ce = v;
    endtask
    // Tasks are entered just after a falling edge and return at a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // No command follows until busy reads low or 40 status reads have passed; an update is not assumed done by it.
    task automatic wait_idle(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            rd(8'h07, s);
            ok = (s[0] === 1'b0);
        end
    endtask
endmodule

/* sim/power_mode_command_unit_tb.sv */
// Self-checking bench of the power mode command unit.
`timescale 1ns/1ps
module power_mode_command_unit_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rate_cfg_wr = 1'b0;
    logic avg_cfg_wr = 1'b0;
    logic cmd_error_clr = 1'b0;
    logic ce, reg_wr, reg_rd, cmd_error_flag, continuous_mode_active, cmd_start, ok;
    logic apply_rate_averaging;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, s;
    logic [2:0] axis_en;
    logic [3:0] cmd_code;
    int bad_count = 0;
    int checks_done = 0;
    // Each row is {illegal, code} for a command issued from sleep.
    logic [4:0] rows [10] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h19, 5'h1f};
    always #50 clk = ~clk;
    pmcu_host host (.clk(clk), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pmcu_top #(.BUSY_CYCLES(3)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rate_cfg_wr(rate_cfg_wr), .avg_cfg_wr(avg_cfg_wr),
        .cmd_error_clr(cmd_error_clr), .cmd_error_flag(cmd_error_flag), .axis_en(axis_en),
        .continuous_mode_active(continuous_mode_active), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .apply_rate_averaging(apply_rate_averaging));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic settle();
        host.wait_idle(ok);
        chk("idle", {7'h0, ok}, 8'h01);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk("axis_en", {5'h0, axis_en}, 8'h07);
        host.rd(8'h05, s);
        chk("axis reg", s, 8'h07);
        host.rd(8'h06, s);
        chk("cmd reg", s, 8'h00);
        host.rd(8'h07, s);
        chk("status", s, 8'h00);
        host.wr(8'h05, 8'hfa);
        chk("axis_en", {5'h0, axis_en}, 8'h02);
        host.rd(8'h05, s);
        chk("axis reg", s, 8'h02);
        rst_b = 1'b0;
        @(negedge clk);
        chk("axis_en", {5'h0, axis_en}, 8'h07);
        rst_b = 1'b1;
        for (int i = 0; i < 10; i++) begin
            host.wr(8'h06, {4'h0, rows[i][3:0]});
            chk("cmd_start", {7'h0, cmd_start}, {7'h0, !rows[i][4]});
            chk("cmd_code", {4'h0, cmd_code}, {4'h0, rows[i][3:0]});
            chk("apply", {7'h0, apply_rate_averaging}, {7'h0, rows[i] == 5'h02});
            host.rd(8'h07, s);
            chk("status", s, {3'h0, rows[i][4], 4'h1});
            host.wait_idle(ok);
            chk("idle", {7'h0, ok}, 8'h01);
        end
        host.wr(8'h06, 8'h05);
        host.wr(8'h06, 8'h07);
        chk("err flag", {7'h0, cmd_error_flag}, 8'h01);
        chk("cmd_code", {4'h0, cmd_code}, 8'h05);
        chk("cmd_start", {7'h0, cmd_start}, 8'h00);
        cmd_error_clr = 1'b1;
        @(negedge clk);
        cmd_error_clr = 1'b0;
        chk("err flag", {7'h0, cmd_error_flag}, 8'h00);
        settle();
        rate_cfg_wr = 1'b1;
        avg_cfg_wr = 1'b1;
        @(negedge clk);
        rate_cfg_wr = 1'b0;
        avg_cfg_wr = 1'b0;
        host.rd(8'h07, s);
        chk("overwrite", s, 8'h06);
        host.wr(8'h06, 8'h02);
        chk("apply", {7'h0, apply_rate_averaging}, 8'h01);
        settle();
        host.rd(8'h07, s);
        chk("status", s, 8'h00);
        host.wr(8'h06, 8'h01);
        settle();
        host.rd(8'h07, s);
        chk("status", s, 8'h08);
        chk("cont", {7'h0, continuous_mode_active}, 8'h01);
        host.wr(8'h06, 8'h03);
        chk("cmd_start", {7'h0, cmd_start}, 8'h00);
        host.rd(8'h07, s);
        chk("status", s, 8'h19);
        settle();
        host.wr(8'h06, 8'h02);
        chk("apply", {7'h0, apply_rate_averaging}, 8'h01);
        settle();
        host.wr(8'h06, 8'h00);
        settle();
        host.rd(8'h07, s);
        chk("status", s, 8'h00);
        // A low clock enable must hold busy, the start pulse and the axis register.
        host.wr(8'h06, 8'h06);
        host.set_ce(1'b0);
        host.wr(8'h05, 8'h00);
        repeat (4) @(negedge clk);
        host.set_ce(1'b1);
        chk("frozen axis", {5'h0, axis_en}, 8'h07);
        chk("frozen start", {7'h0, cmd_start}, 8'h01);
        host.rd(8'h07, s);
        chk("frozen busy", s, 8'h01);
        settle();
        host.rd(8'h0e, s);
        chk("unmapped", s, 8'h00);
        give_verdict();
    end
endmodule

/* verilog/pmcu_pkg.sv */
// Constants shared by the power mode command unit.
package pmcu_pkg;
    localparam logic [7:0] AXIS_EN_OFS = 8'h05;
    localparam logic [7:0] CMD_OFS = 8'h06;
    localparam logic [7:0] STATUS_OFS = 8'h07;
    localparam logic [7:0] AXIS_EN_RST = 8'h07;
    localparam logic [3:0] CMD_RST = 4'h0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RATE_OVW_BIT = 1;
    localparam int ST_AVG_OVW_BIT = 2;
    localparam int ST_CONT_BIT = 3;
    localparam int ST_ILL_BIT = 4;
    localparam logic [3:0] ENTER_SLEEP_STATE = 4'h0;
    localparam logic [3:0] CONTINUOUS_MEASURE_MODE = 4'h1;
    localparam logic [3:0] APPLY_RATE_AVERAGING = 4'h2;
    localparam logic [3:0] SINGLE_SHOT_FULL = 4'h3;
    localparam logic [3:0] SINGLE_SHOT_QUICK = 4'h4;
    localparam logic [3:0] FLUX_GUIDE_RESET_FULL = 4'h5;
    localparam logic [3:0] FLUX_GUIDE_RESET_QUICK = 4'h6;
    localparam logic [3:0] BIT_RESET_FULL = 4'h7;
    localparam logic [3:0] BIT_RESET_QUICK = 4'h8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CMD_TIME_NS = 1000;
    localparam int CMD_CYCLES = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        PMCU_SLEEP = 3'h1,
        PMCU_CONT = 3'h2,
        PMCU_SINGLE = 3'h4
    } pmcu_mode_t;
endpackage

/* verilog/pmcu_top.sv */
// Power mode command unit: axis enables, command decode and command status.
`timescale 1ns/1ps
module pmcu_top #(
    parameter int BUSY_CYCLES = pmcu_pkg::CMD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rate_cfg_wr,
    input wire logic avg_cfg_wr,
    input wire logic cmd_error_clr,
    output logic cmd_error_flag,
    output logic [2:0] axis_en,
    output logic continuous_mode_active,
    output logic cmd_start,
    output logic [3:0] cmd_code,
    output logic apply_rate_averaging
);
    localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYCLES);

    // Legal means a known code that the present power mode lets through.
    function automatic logic cmd_legal(input logic [3:0] code, input logic in_cont);
        logic known;
        known = (code <= pmcu_pkg::BIT_RESET_QUICK);
        cmd_legal = known && (!in_cont || code == pmcu_pkg::ENTER_SLEEP_STATE ||
            code == pmcu_pkg::APPLY_RATE_AVERAGING);
    endfunction

    pmcu_pkg::pmcu_mode_t mode_ff, nxt_mode;
    logic [7:0] busy_cnt_ff, nxt_busy_cnt;
    logic [2:0] axis_en_ff, nxt_axis_en;
    logic [3:0] cmd_ff, nxt_cmd;
    logic ill_ff, nxt_ill;
    logic rate_ovw_ff, nxt_rate_ovw;
    logic avg_ovw_ff, nxt_avg_ovw;
    logic err_ff, nxt_err;
    logic start_ff, nxt_start;
    logic apply_ff, nxt_apply;
    logic [7:0] rdata_ff, nxt_rdata;
    logic busy, in_cont, cmd_wr, accept, refuse_ill, refuse_busy;
    logic [3:0] wcode;
    logic [7:0] status;

    assign busy = (busy_cnt_ff != 8'h00);
    assign in_cont = (mode_ff == pmcu_pkg::PMCU_CONT);
    assign wcode = reg_wdata[3:0];
    assign cmd_wr = reg_wr && (reg_addr == pmcu_pkg::CMD_OFS);
    assign refuse_busy = cmd_wr && busy;
    assign accept = cmd_wr && !busy && cmd_legal(wcode, in_cont);
    assign refuse_ill = cmd_wr && !busy && !cmd_legal(wcode, in_cont);
    // Bits 7:5 of the status register are reserved and read as zero.
    assign status = {3'h0, ill_ff, in_cont, avg_ovw_ff, rate_ovw_ff, busy};

    always_comb begin
        nxt_mode = mode_ff;
        nxt_busy_cnt = busy_cnt_ff;
        nxt_axis_en = axis_en_ff;
        nxt_cmd = cmd_ff;
        nxt_ill = ill_ff;
        nxt_rate_ovw = rate_ovw_ff;
        nxt_avg_ovw = avg_ovw_ff;
        nxt_err = err_ff;
        nxt_start = 1'b0;
        nxt_apply = 1'b0;
        nxt_rdata = rdata_ff;
        if (reg_wr && reg_addr == pmcu_pkg::AXIS_EN_OFS) begin
            nxt_axis_en = reg_wdata[2:0];
        end
        // A busy-time write only raises the error flag; an illegal one still occupies the unit.
        if (busy) begin
            nxt_busy_cnt = busy_cnt_ff - 8'h01;
        end
        if (cmd_wr && !busy) begin
            nxt_cmd = wcode;
            nxt_busy_cnt = BUSY_LOAD;
        end
        // A single-shot measurement drops back to sleep when its processing ends.
        if (mode_ff == pmcu_pkg::PMCU_SINGLE && busy_cnt_ff == 8'h01) begin
            nxt_mode = pmcu_pkg::PMCU_SLEEP;
        end
        if (accept) begin
            nxt_start = 1'b1;
            nxt_ill = 1'b0;
            unique case (wcode)
                pmcu_pkg::ENTER_SLEEP_STATE: nxt_mode = pmcu_pkg::PMCU_SLEEP;
                pmcu_pkg::CONTINUOUS_MEASURE_MODE: nxt_mode = pmcu_pkg::PMCU_CONT;
                pmcu_pkg::SINGLE_SHOT_FULL,
                pmcu_pkg::SINGLE_SHOT_QUICK: nxt_mode = pmcu_pkg::PMCU_SINGLE;
                default: nxt_mode = nxt_mode;
            endcase
            if (wcode == pmcu_pkg::APPLY_RATE_AVERAGING) begin
                nxt_apply = 1'b1;
                nxt_rate_ovw = 1'b0;
                nxt_avg_ovw = 1'b0;
            end
        end
        if (refuse_ill) begin
            nxt_ill = 1'b1;
        end
        // New pending values win over the clear done by an update.
        if (rate_cfg_wr) begin
            nxt_rate_ovw = 1'b1;
        end
        if (avg_cfg_wr) begin
            nxt_avg_ovw = 1'b1;
        end
        if (cmd_error_clr) begin
            nxt_err = 1'b0;
        end
        if (refuse_busy) begin
            nxt_err = 1'b1;
        end
        // The write-only command register and unmapped offsets read as zero.
        if (reg_rd) begin
            unique case (reg_addr)
                pmcu_pkg::AXIS_EN_OFS: nxt_rdata = {5'h00, axis_en_ff};
                pmcu_pkg::STATUS_OFS: nxt_rdata = status;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= pmcu_pkg::PMCU_SLEEP;
            busy_cnt_ff <= 8'h00;
            axis_en_ff <= pmcu_pkg::AXIS_EN_RST[2:0];
            cmd_ff <= pmcu_pkg::CMD_RST;
            ill_ff <= pmcu_pkg::STATUS_RST[pmcu_pkg::ST_ILL_BIT];
            rate_ovw_ff <= pmcu_pkg::STATUS_RST[pmcu_pkg::ST_RATE_OVW_BIT];
            avg_ovw_ff <= pmcu_pkg::STATUS_RST[pmcu_pkg::ST_AVG_OVW_BIT];
            err_ff <= 1'b0;
            start_ff <= 1'b0;
            apply_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (ce) begin
            mode_ff <= nxt_mode;
            busy_cnt_ff <= nxt_busy_cnt;
            axis_en_ff <= nxt_axis_en;
            cmd_ff <= nxt_cmd;
            ill_ff <= nxt_ill;
            rate_ovw_ff <= nxt_rate_ovw;
            avg_ovw_ff <= nxt_avg_ovw;
            err_ff <= nxt_err;
            start_ff <= nxt_start;
            apply_ff <= nxt_apply;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign cmd_error_flag = err_ff;
    assign axis_en = axis_en_ff;
    assign continuous_mode_active = in_cont;
    assign cmd_start = start_ff;
    assign cmd_code = cmd_ff;
    assign apply_rate_averaging = apply_ff;

    // Counts how long busy has stood since the last load, for the busy length check.
    logic [7:0] busy_age_ff, nxt_busy_age;
    always_comb begin
        nxt_busy_age = 8'h00;
        if (busy) begin
            nxt_busy_age = busy_age_ff + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_age_ff <= 8'h00;
        end else if (ce) begin
            busy_age_ff <= nxt_busy_age;
        end
    end

    axis_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_wr && reg_addr == pmcu_pkg::AXIS_EN_OFS |=> axis_en == $past(reg_wdata[2:0]))
        else $error("axis enable not written");

    cmd_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !busy |=> cmd_code == $past(wcode) && cmd_start == $past(accept))
        else $error("command not stored");

    mode_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && wcode == pmcu_pkg::CONTINUOUS_MEASURE_MODE |=> continuous_mode_active)
        else $error("continuous mode not entered");

    single_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && (wcode == pmcu_pkg::SINGLE_SHOT_FULL ||
        wcode == pmcu_pkg::SINGLE_SHOT_QUICK) |=> mode_ff == pmcu_pkg::PMCU_SINGLE && busy)
        else $error("single shot not started");

    // A single shot must fall back to sleep on the same edge that ends busy.
    single_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && mode_ff == pmcu_pkg::PMCU_SINGLE && busy_cnt_ff == 8'h01 |=>
        mode_ff == pmcu_pkg::PMCU_SLEEP && !busy)
        else $error("single shot did not return to sleep");

    cont_block_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !busy && in_cont && wcode == pmcu_pkg::SINGLE_SHOT_FULL |=>
        !cmd_start && continuous_mode_active && status[pmcu_pkg::ST_ILL_BIT])
        else $error("blocked command took effect");

    illegal_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !busy && wcode > pmcu_pkg::BIT_RESET_QUICK |=>
        status[pmcu_pkg::ST_ILL_BIT] && !cmd_start)
        else $error("illegal code not flagged");

    apply_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && wcode == pmcu_pkg::APPLY_RATE_AVERAGING |=> apply_rate_averaging)
        else $error("update pulse missing");

    apply_once_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && apply_rate_averaging |=> !apply_rate_averaging)
        else $error("update pulse too long");

    busy_len_a: assert property (@(posedge clk) disable iff (!rst_b)
        busy |-> busy_age_ff < BUSY_LOAD)
        else $error("busy stood too long");

    busy_error_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && refuse_busy |=> cmd_error_flag && $stable(cmd_code))
        else $error("busy write not refused");

    ovw_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && rate_cfg_wr |=> status[pmcu_pkg::ST_RATE_OVW_BIT])
        else $error("rate overwrite not flagged");

    avg_ovw_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && avg_cfg_wr |=> status[pmcu_pkg::ST_AVG_OVW_BIT])
        else $error("averaging overwrite not flagged");

    ovw_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && wcode == pmcu_pkg::APPLY_RATE_AVERAGING && !rate_cfg_wr && !avg_cfg_wr
        |=> !status[pmcu_pkg::ST_RATE_OVW_BIT] && !status[pmcu_pkg::ST_AVG_OVW_BIT])
        else $error("overwrite flags not cleared by update");

    err_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_error_clr && !refuse_busy |=> !cmd_error_flag)
        else $error("error flag not cleared");

    ill_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && refuse_ill |=> status[pmcu_pkg::ST_ILL_BIT] && !cmd_start && busy)
        else $error("illegal command not flagged");

    ill_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept |=> !status[pmcu_pkg::ST_ILL_BIT] && cmd_start)
        else $error("illegal flag not cleared by accepted command");

    sleep_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && wcode == pmcu_pkg::ENTER_SLEEP_STATE |=>
        mode_ff == pmcu_pkg::PMCU_SLEEP && !continuous_mode_active)
        else $error("sleep not entered");

    reset_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && accept && wcode >= pmcu_pkg::FLUX_GUIDE_RESET_FULL &&
        wcode <= pmcu_pkg::BIT_RESET_QUICK |=> cmd_start && cmd_code == $past(wcode))
        else $error("reset command not issued");

    busy_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !busy |=> busy && status[pmcu_pkg::ST_BUSY_BIT])
        else $error("busy not raised by command");

    cont_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !busy && in_cont && wcode == pmcu_pkg::APPLY_RATE_AVERAGING |=>
        cmd_start && apply_rate_averaging && continuous_mode_active)
        else $error("allowed command blocked in continuous mode");

    // A low clock enable must freeze the command state, busy count included.
    freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(busy_cnt_ff) && $stable(mode_ff) && $stable(cmd_code))
        else $error("state moved while clock enable low");

    axis_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == pmcu_pkg::AXIS_EN_OFS |=>
        reg_rdata == {5'h00, $past(axis_en)})
        else $error("axis enable read wrong");

    cmd_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == pmcu_pkg::CMD_OFS |=> reg_rdata == 8'h00)
        else $error("command register not write-only");

    rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule
